/* File: rtl/csfu_top.sv */
// CPU status flags unit: condition register, ALU flag update, branch helpers
// Function
// - Eight-bit condition register; top four bits branch-testable, next two for BCD.
// - Carry set on carry out of or borrow into bit 7.
// - Rotates and shifts load carry with last bit shifted out.
// - Dedicated operations set, clear or invert carry.
// - Zero set when operation result equals zero.
// - Sign copies result most significant bit.
// - Overflow on signed range exceed; cleared by logic operations.
// - AND updates zero and sign from its result and clears overflow.
// - Decimal type bit records add or subtract; never a branch condition.
// - Half carry on carry out of bit 3 or borrow from bit 4.
// - Decimal correction uses half carry and type bit for BCD.
// - Fast service bit set on fast interrupt, cleared by its return.
// - Fast service bit blocks interrupts, selects fast return path.
// - Bit 0 selects set-1 bank; bank ops clear or set it.
// - Condition register writable by non-flag operations such as loads.
// - Flag op plus register write at once is unpredictable; no priority defined. Here the bus write wins.
// - Branch target is next address plus signed eight-bit offset.
// - Register pair addresses must be even, up to 254 or 14.
// - Four-bit condition field tests carry, zero, sign, overflow.
`timescale 1ns/1ps
module csfu_top
(
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  wire csfu_pkg::csfu_req_type REQ,
    input  wire csfu_pkg::csfu_bus_type BUS,
    input  wire logic [3:0]            COND_CODE,
    input  wire logic [15:0]           NEXT_PC,
    input  wire logic [7:0]            BR_OFFSET,
    input  wire logic [7:0]            PAIR_ADDR,
    input  wire logic                  PAIR_IS_WREG,
    output csfu_pkg::csfu_res_type     RES,
    output logic [7:0]                 RDATA,
    output logic [7:0]                 FLAGS_OUT,
    output logic                       COND_TRUE,
    output logic [15:0]                BR_TARGET,
    output logic                       PAIR_OK,
    output logic                       INT_BLOCK,
    output logic                       FAST_RETURN
);
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] result_d;
    logic       res_valid_d;
    logic       c_d, z_d, s_d, v_d, d_d, h_d;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] b_op;
    logic       cin;
    logic       is_sub;
    logic [7:0] adj;
    logic       dcarry;

    wire logic       c_q       = flags_q[csfu_pkg::CSFU_CARRY_POS];
    wire logic       z_q       = flags_q[csfu_pkg::CSFU_ZERO_POS];
    wire logic       s_q       = flags_q[csfu_pkg::CSFU_SIGN_POS];
    wire logic       v_q       = flags_q[csfu_pkg::CSFU_OVFL_POS];
    wire logic       reg_hit   = BUS.addr == csfu_pkg::CSFU_FLAGS_ADDR;
    wire logic       reg_write = BUS.write && reg_hit;
    wire logic       op_go     = REQ.valid;

    // Condition field evaluation, low three bits pick test, bit 3 inverts
    function automatic logic cond_eval(input logic [3:0] cc, input logic [7:0] f);
        logic c, z, s, v, t;
        c = f[csfu_pkg::CSFU_CARRY_POS];
        z = f[csfu_pkg::CSFU_ZERO_POS];
        s = f[csfu_pkg::CSFU_SIGN_POS];
        v = f[csfu_pkg::CSFU_OVFL_POS];
        case (cc[2:0])
            3'h0:    t = 1'b0;
            3'h1:    t = s ^ v;
            3'h2:    t = z | (s ^ v);
            3'h3:    t = c | z;
            3'h4:    t = v;
            3'h5:    t = s;
            3'h6:    t = z;
            3'h7:    t = c;
            default: t = 1'b0;
        endcase
        return t ^ cc[3];
    endfunction

    // Adder operand selection and carry in
    always_comb
    begin
        is_sub = 1'b0;
        cin    = 1'b0;
        b_op   = REQ.src;
        case (REQ.op)
            csfu_pkg::CSFU_OP_ADC: cin = c_q;
            csfu_pkg::CSFU_OP_SUB, csfu_pkg::CSFU_OP_CP:
            begin
                is_sub = 1'b1;
                b_op   = ~REQ.src;
                cin    = 1'b1;
            end
            csfu_pkg::CSFU_OP_SBC:
            begin
                is_sub = 1'b1;
                b_op   = ~REQ.src;
                cin    = ~c_q;
            end
            csfu_pkg::CSFU_OP_INC: b_op = 8'h01;
            csfu_pkg::CSFU_OP_DEC:
            begin
                is_sub = 1'b1;
                b_op   = 8'hFE;
                cin    = 1'b1;
            end
            default: b_op = REQ.src;
        endcase
    end

    assign sum9 = {1'b0, REQ.dst} + {1'b0, b_op} + {8'h00, cin};
    assign sum5 = {1'b0, REQ.dst[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};

    // Decimal correction from half carry, carry and type bit
    always_comb
    begin
        adj    = 8'h00;
        dcarry = c_q;
        if (!flags_q[csfu_pkg::CSFU_DECSUB_POS])
        begin
            if (flags_q[csfu_pkg::CSFU_HALF_POS] || (REQ.dst[3:0] > 4'h9))
                adj = 8'h06;
            if (c_q || (REQ.dst > 8'h99))
            begin
                adj    = adj | 8'h60;
                dcarry = 1'b1;
            end
        end
        else
        begin
            if (flags_q[csfu_pkg::CSFU_HALF_POS])
                adj = 8'hFA;
            if (c_q)
                adj = adj + 8'hA0;
        end
    end

    // Result and flag computation
    always_comb
    begin
        c_d         = c_q;
        z_d         = z_q;
        s_d         = s_q;
        v_d         = v_q;
        d_d         = flags_q[csfu_pkg::CSFU_DECSUB_POS];
        h_d         = flags_q[csfu_pkg::CSFU_HALF_POS];
        result_d    = REQ.dst;
        res_valid_d = 1'b0;
        case (REQ.op)
            csfu_pkg::CSFU_OP_ADD, csfu_pkg::CSFU_OP_ADC, csfu_pkg::CSFU_OP_SUB,
            csfu_pkg::CSFU_OP_SBC, csfu_pkg::CSFU_OP_CP:
            begin
                result_d    = sum9[7:0];
                res_valid_d = REQ.op != csfu_pkg::CSFU_OP_CP;
                c_d = sum9[8] ^ is_sub;
                z_d = sum9[7:0] == 8'h00;
                s_d = sum9[7];
                v_d = (REQ.dst[7] == b_op[7]) && (sum9[7] != REQ.dst[7]);
                if (REQ.op != csfu_pkg::CSFU_OP_CP)
                begin
                    d_d = is_sub;
                    h_d = sum5[4] ^ is_sub;
                end
            end
            csfu_pkg::CSFU_OP_INC, csfu_pkg::CSFU_OP_DEC:
            begin
                result_d    = sum9[7:0];
                res_valid_d = 1'b1;
                z_d = sum9[7:0] == 8'h00;
                s_d = sum9[7];
                v_d = (REQ.dst[7] == b_op[7]) && (sum9[7] != REQ.dst[7]);
            end
            csfu_pkg::CSFU_OP_AND, csfu_pkg::CSFU_OP_OR, csfu_pkg::CSFU_OP_XOR,
            csfu_pkg::CSFU_OP_COM, csfu_pkg::CSFU_OP_TEST:
            begin
                case (REQ.op)
                    csfu_pkg::CSFU_OP_AND:  result_d = REQ.dst & REQ.src;
                    csfu_pkg::CSFU_OP_OR:   result_d = REQ.dst | REQ.src;
                    csfu_pkg::CSFU_OP_XOR:  result_d = REQ.dst ^ REQ.src;
                    csfu_pkg::CSFU_OP_COM:  result_d = ~REQ.dst;
                    default:                result_d = REQ.dst & REQ.src;
                endcase
                res_valid_d = REQ.op != csfu_pkg::CSFU_OP_TEST;
                z_d = result_d == 8'h00;
                s_d = result_d[7];
                v_d = 1'b0;
            end
            csfu_pkg::CSFU_OP_RL, csfu_pkg::CSFU_OP_RLC, csfu_pkg::CSFU_OP_RR,
            csfu_pkg::CSFU_OP_RRC, csfu_pkg::CSFU_OP_SRA:
            begin
                case (REQ.op)
                    csfu_pkg::CSFU_OP_RL:  result_d = {REQ.dst[6:0], REQ.dst[7]};
                    csfu_pkg::CSFU_OP_RLC: result_d = {REQ.dst[6:0], c_q};
                    csfu_pkg::CSFU_OP_RR:  result_d = {REQ.dst[0], REQ.dst[7:1]};
                    csfu_pkg::CSFU_OP_RRC: result_d = {c_q, REQ.dst[7:1]};
                    default:               result_d = {REQ.dst[7], REQ.dst[7:1]};
                endcase
                res_valid_d = 1'b1;
                c_d = (REQ.op == csfu_pkg::CSFU_OP_RL || REQ.op == csfu_pkg::CSFU_OP_RLC)
                    ? REQ.dst[7] : REQ.dst[0];
                z_d = result_d == 8'h00;
                s_d = result_d[7];
                v_d = (REQ.op == csfu_pkg::CSFU_OP_SRA) ? 1'b0 : (result_d[7] ^ REQ.dst[7]);
            end
            csfu_pkg::CSFU_OP_DADJ:
            begin
                result_d    = REQ.dst + adj;
                res_valid_d = 1'b1;
                c_d = flags_q[csfu_pkg::CSFU_DECSUB_POS] ? c_q : dcarry;
                z_d = result_d == 8'h00;
                s_d = result_d[7];
            end
            csfu_pkg::CSFU_OP_SCF: c_d = 1'b1;
            csfu_pkg::CSFU_OP_RCF: c_d = 1'b0;
            csfu_pkg::CSFU_OP_CCF: c_d = ~c_q;
            default: c_d = c_q;
        endcase
    end

    // Next flag register value; a bus write overrides a flag op in the same cycle
    always_comb
    begin
        flags_d = {c_d, z_d, s_d, v_d, d_d, h_d,
                   flags_q[csfu_pkg::CSFU_FAST_POS], flags_q[csfu_pkg::CSFU_BANK_POS]};
        case (REQ.op)
            csfu_pkg::CSFU_OP_FENT: flags_d[csfu_pkg::CSFU_FAST_POS] = 1'b1;
            csfu_pkg::CSFU_OP_INT_RETURN: flags_d[csfu_pkg::CSFU_FAST_POS] = 1'b0;
            csfu_pkg::CSFU_OP_SBZ:  flags_d[csfu_pkg::CSFU_BANK_POS] = 1'b0;
            csfu_pkg::CSFU_OP_SBO:  flags_d[csfu_pkg::CSFU_BANK_POS] = 1'b1;
            default: flags_d[csfu_pkg::CSFU_BANK_POS] = flags_q[csfu_pkg::CSFU_BANK_POS];
        endcase
        if (!op_go)
            flags_d = flags_q;
        if (reg_write)
            flags_d = BUS.wdata;
    end

    wire logic [15:0] br_sum   = NEXT_PC + {{8{BR_OFFSET[7]}}, BR_OFFSET};
    wire logic        pair_lim = PAIR_IS_WREG ? (PAIR_ADDR <= {4'h0, csfu_pkg::CSFU_PAIR_WREG_MAX})
                                              : (PAIR_ADDR <= csfu_pkg::CSFU_PAIR_ADDR_MAX);
    wire logic        pair_ok  = !PAIR_ADDR[0] && pair_lim;
    wire logic        cond_now = cond_eval(COND_CODE, flags_d);

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            flags_q     <= csfu_pkg::CSFU_FLAGS_RESET;
            RES         <= '0;
            RDATA       <= 8'h00;
            COND_TRUE   <= 1'b0;
            BR_TARGET   <= 16'h0000;
            PAIR_OK     <= 1'b0;
            INT_BLOCK   <= 1'b0;
            FAST_RETURN <= 1'b0;
        end
        else
        begin
            flags_q          <= flags_d;
            RES.result       <= result_d;
            RES.result_valid <= op_go && res_valid_d;
            RDATA            <= (BUS.read && reg_hit) ? flags_q : 8'h00;
            COND_TRUE        <= cond_now;
            BR_TARGET        <= br_sum;
            PAIR_OK          <= pair_ok;
            INT_BLOCK        <= flags_d[csfu_pkg::CSFU_FAST_POS];
            FAST_RETURN      <= op_go && (REQ.op == csfu_pkg::CSFU_OP_INT_RETURN)
                                && flags_q[csfu_pkg::CSFU_FAST_POS];
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            FLAGS_OUT <= csfu_pkg::CSFU_FLAGS_RESET;
        else
            FLAGS_OUT <= flags_d;
    end

    property p_zero_after_and;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_AND && !reg_write)
        |=> flags_q[6] == ($past(REQ.dst & REQ.src) == 8'h00) && !flags_q[4];
    endproperty
    a_zero_after_and: assert property (p_zero_after_and) else $error("AND flags wrong");

    property p_carry_add;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_ADD && !reg_write)
        |=> flags_q[7] == $past(({1'b0, REQ.dst} + {1'b0, REQ.src}) > 9'h0FF);
    endproperty
    a_carry_add: assert property (p_carry_add) else $error("Add carry wrong");

    property p_rot_carry;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_RR && !reg_write)
        |=> flags_q[7] == $past(REQ.dst[0]) && RES.result_valid;
    endproperty
    a_rot_carry: assert property (p_rot_carry) else $error("Rotate carry wrong");

    property p_ccf;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_CCF && !reg_write)
        |=> flags_q[7] != $past(flags_q[7]);
    endproperty
    a_ccf: assert property (p_ccf) else $error("Carry invert wrong");

    property p_sign;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_XOR && !reg_write)
        |=> flags_q[5] == RES.result[7];
    endproperty
    a_sign: assert property (p_sign) else $error("Sign wrong");

    property p_sub_type;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_SUB && !reg_write) |=> flags_q[3];
    endproperty
    a_sub_type: assert property (p_sub_type) else $error("Type bit wrong");

    property p_fast;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_FENT && !reg_write)
        |=> flags_q[1] && INT_BLOCK;
    endproperty
    a_fast: assert property (p_fast) else $error("Fast service wrong");

    property p_bank;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_SBO && !reg_write) |=> flags_q[0];
    endproperty
    a_bank: assert property (p_bank) else $error("Bank select wrong");

    property p_load;
        @(posedge SYS_CLK) disable iff (RST)
        reg_write |=> flags_q == $past(BUS.wdata);
    endproperty
    a_load: assert property (p_load) else $error("Register load wrong");

    property p_half_add;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_ADD && !reg_write)
        |=> flags_q[csfu_pkg::CSFU_HALF_POS]
            == $past(({1'b0, REQ.dst[3:0]} + {1'b0, REQ.src[3:0]}) > 5'h0F);
    endproperty
    a_half_add: assert property (p_half_add) else $error("Half carry wrong");

    property p_bank_zero;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_SBZ && !reg_write)
        |=> !flags_q[csfu_pkg::CSFU_BANK_POS];
    endproperty
    a_bank_zero: assert property (p_bank_zero) else $error("Bank zero select wrong");

    property p_fast_return;
        @(posedge SYS_CLK) disable iff (RST)
        (REQ.valid && REQ.op == csfu_pkg::CSFU_OP_INT_RETURN && !reg_write
         && flags_q[csfu_pkg::CSFU_FAST_POS])
        |=> !flags_q[csfu_pkg::CSFU_FAST_POS] && FAST_RETURN && !INT_BLOCK;
    endproperty
    a_fast_return: assert property (p_fast_return) else $error("Fast return wrong");

    property p_pair_odd;
        @(posedge SYS_CLK) disable iff (RST)
        PAIR_ADDR[0] |=> !PAIR_OK;
    endproperty
    a_pair_odd: assert property (p_pair_odd) else $error("Odd pair accepted");

    property p_rdata_idle;
        @(posedge SYS_CLK) disable iff (RST)
        !(BUS.read && reg_hit) |=> RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not cleared");

    c_and:  cover property (@(posedge SYS_CLK) REQ.valid && REQ.op == csfu_pkg::CSFU_OP_AND);
    c_dadj: cover property (@(posedge SYS_CLK) REQ.valid && REQ.op == csfu_pkg::CSFU_OP_DADJ);
    c_fent: cover property (@(posedge SYS_CLK) REQ.valid && REQ.op == csfu_pkg::CSFU_OP_FENT);
    c_int_return: cover property (@(posedge SYS_CLK) FAST_RETURN);
endmodule

/* File: include/csfu_pkg.sv */
// Package for the CPU status flags unit
package csfu_pkg;
    localparam logic [7:0] CSFU_FLAGS_ADDR  = 8'hD5;
    localparam logic [7:0] CSFU_FLAGS_RESET = 8'h00;
    localparam int         CSFU_CARRY_POS   = 7;
    localparam int         CSFU_ZERO_POS    = 6;
    localparam int         CSFU_SIGN_POS    = 5;
    localparam int         CSFU_OVFL_POS    = 4;
    localparam int         CSFU_DECSUB_POS  = 3;
    localparam int         CSFU_HALF_POS    = 2;
    localparam int         CSFU_FAST_POS    = 1;
    localparam int         CSFU_BANK_POS    = 0;
    localparam logic [7:0] CSFU_PAIR_ADDR_MAX = 8'hFE;
    localparam logic [3:0] CSFU_PAIR_WREG_MAX = 4'hE;

    typedef enum logic [4:0] {
        CSFU_OP_NONE  = 5'h00,
        CSFU_OP_ADD   = 5'h01,
        CSFU_OP_ADC   = 5'h02,
        CSFU_OP_SUB   = 5'h03,
        CSFU_OP_SBC   = 5'h04,
        CSFU_OP_CP    = 5'h05,
        CSFU_OP_INC   = 5'h06,
        CSFU_OP_DEC   = 5'h07,
        CSFU_OP_AND   = 5'h08,
        CSFU_OP_OR    = 5'h09,
        CSFU_OP_XOR   = 5'h0A,
        CSFU_OP_COM   = 5'h0B,
        CSFU_OP_TEST  = 5'h0C,
        CSFU_OP_RL    = 5'h0D,
        CSFU_OP_RLC   = 5'h0E,
        CSFU_OP_RR    = 5'h0F,
        CSFU_OP_RRC   = 5'h10,
        CSFU_OP_SRA   = 5'h11,
        CSFU_OP_DADJ  = 5'h12,
        CSFU_OP_SCF   = 5'h13,
        CSFU_OP_RCF   = 5'h14,
        CSFU_OP_CCF   = 5'h15,
        CSFU_OP_SBZ   = 5'h16,
        CSFU_OP_SBO   = 5'h17,
        CSFU_OP_FENT  = 5'h18,
        CSFU_OP_INT_RETURN = 5'h19
    } csfu_op_type;

    typedef struct packed {
        logic        valid;
        csfu_op_type op;
        logic [7:0]  dst;
        logic [7:0]  src;
    } csfu_req_type;

    typedef struct packed {
        logic [7:0] result;
        logic       result_valid;
    } csfu_res_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } csfu_bus_type;
endpackage

/* File: bench/tb_top.sv */
// Self-checking testbench for the CPU status flags unit
`timescale 1ns/1ps
module tb_top;
    logic                   sys_clk;
    logic                   rst;
    csfu_pkg::csfu_req_type req;
    csfu_pkg::csfu_bus_type bus;
    logic [3:0]             cond_code;
    logic [15:0]            next_pc;
    logic [7:0]             br_offset;
    logic [7:0]             pair_addr;
    logic                   pair_is_wreg;
    csfu_pkg::csfu_res_type res;
    logic [7:0]             rdata;
    logic [7:0]             flags_out;
    logic                   cond_true;
    logic [15:0]            br_target;
    logic                   pair_ok;
    logic                   int_block;
    logic                   fast_return;
    int                     num_errors;
    int                     n_tests;
    int                     cycles;

    csfu_top dut_u
    (
        .SYS_CLK      (sys_clk),
        .RST          (rst),
        .REQ          (req),
        .BUS          (bus),
        .COND_CODE    (cond_code),
        .NEXT_PC      (next_pc),
        .BR_OFFSET    (br_offset),
        .PAIR_ADDR    (pair_addr),
        .PAIR_IS_WREG (pair_is_wreg),
        .RES          (res),
        .RDATA        (rdata),
        .FLAGS_OUT    (flags_out),
        .COND_TRUE    (cond_true),
        .BR_TARGET    (br_target),
        .PAIR_OK      (pair_ok),
        .INT_BLOCK    (int_block),
        .FAST_RETURN  (fast_return)
    );

    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk16(input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Register port write, then read with data checked in the following cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{write: 1'h1, read: 1'h0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus <= '{write: 1'h0, read: 1'h1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        chk8(exp, rdata);
        @(posedge sys_clk);
        #1;
        chk8(8'h00, rdata);
    endtask

    // One operation request; result and masked flags checked one cycle later
    task automatic op_chk(input csfu_pkg::csfu_op_type o, input logic [7:0] d,
                          input logic [7:0] s, input logic [7:0] exp_res,
                          input logic [7:0] exp_flags, input logic [7:0] mask);
        @(posedge sys_clk);
        req <= '{valid: 1'h1, op: o, dst: d, src: s};
        @(posedge sys_clk);
        req.valid <= 1'h0;
        #1;
        if (mask == 8'hFF)
            chk8(8'h01, {7'h00, res.result_valid});
        chk8(exp_res, res.result);
        chk8(exp_flags & mask, flags_out & mask);
    endtask

    task automatic op_only(input csfu_pkg::csfu_op_type o);
        @(posedge sys_clk);
        req <= '{valid: 1'h1, op: o, dst: 8'h00, src: 8'h00};
        @(posedge sys_clk);
        req.valid <= 1'h0;
        #1;
    endtask

    function automatic logic cond_ref(input logic [7:0] f, input logic [3:0] c);
        logic cy;
        logic z;
        logic s;
        logic v;
        logic t;
        cy = f[7];
        z = f[6];
        s = f[5];
        v = f[4];
        case (c[2:0])
            3'h0: t = 1'h0;
            3'h1: t = s ^ v;
            3'h2: t = z | (s ^ v);
            3'h3: t = cy | z;
            3'h4: t = v;
            3'h5: t = s;
            3'h6: t = z;
            default: t = cy;
        endcase
        return t ^ c[3];
    endfunction

    task automatic t_regs();
        chk8(8'h00, flags_out);
        rd_chk(csfu_pkg::CSFU_FLAGS_ADDR, 8'h00);
        wr_reg(csfu_pkg::CSFU_FLAGS_ADDR, 8'hA5);
        rd_chk(csfu_pkg::CSFU_FLAGS_ADDR, 8'hA5);
        wr_reg(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        rd_chk(csfu_pkg::CSFU_FLAGS_ADDR, 8'hA5);
        $display("test regs done");
    endtask

    task automatic t_arith();
        wr_reg(csfu_pkg::CSFU_FLAGS_ADDR, 8'h00);
        op_chk(csfu_pkg::CSFU_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'hC4, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h34, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_SUB, 8'h00, 8'h10, 8'hF0, 8'hA8, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_ADC, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_ADD, 8'h15, 8'h27, 8'h3C, 8'h00, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_DADJ, 8'h3C, 8'h00, 8'h42, 8'h00, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_SUB, 8'h42, 8'h15, 8'h2D, 8'h0C, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_DADJ, 8'h2D, 8'h00, 8'h27, 8'h0C, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_CP, 8'h00, 8'h01, 8'hFF, 8'hA0, 8'hF0);
        op_chk(csfu_pkg::CSFU_OP_SBC, 8'h10, 8'h01, 8'h0E, 8'h0C, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_INC, 8'h7F, 8'h00, 8'h80, 8'h3C, 8'hFF);
        op_chk(csfu_pkg::CSFU_OP_DEC, 8'h80, 8'h00, 8'h7F, 8'h1C, 8'hFF);
        $display("test arith done");
    endtask

    task automatic t_logic();
        wr_reg(csfu_pkg::CSFU_FLAGS_ADDR, 8'hF0);
        op_chk(csfu_pkg::CSFU_OP_AND, 8'hFF, 8'h00, 8'h00, 8'hC0, 8'hF0);
        op_chk(csfu_pkg::CSFU_OP_OR, 8'h80, 8'h01, 8'h81, 8'hA0, 8'hF0);
        op_chk(csfu_pkg::CSFU_OP_XOR, 8'hAA, 8'hAA, 8'h00, 8'hC0, 8'hF0);
        op_chk(csfu_pkg::CSFU_OP_COM, 8'h55, 8'h00, 8'hAA, 8'hA0, 8'hF0);
        op_chk(csfu_pkg::CSFU_OP_TEST, 8'hF0, 8'h0F, 8'h00, 8'hC0, 8'hF0);
        $display("test logic done");
    endtask

    task automatic t_rotate();
        wr_reg(csfu_pkg::CSFU_FLAGS_ADDR, 8'h00);
        op_chk(csfu_pkg::CSFU_OP_RL, 8'h81, 8'h00, 8'h03, 8'h80, 8'hE0);
        op_chk(csfu_pkg::CSFU_OP_RR, 8'h01, 8'h00, 8'h80, 8'hA0, 8'hE0);
        op_chk(csfu_pkg::CSFU_OP_SRA, 8'h01, 8'h00, 8'h00, 8'hC0, 8'hE0);
        op_chk(csfu_pkg::CSFU_OP_RLC, 8'h00, 8'h00, 8'h01, 8'h00, 8'hE0);
        op_chk(csfu_pkg::CSFU_OP_RRC, 8'h01, 8'h00, 8'h00, 8'hC0, 8'hE0);
        $display("test rotate done");
    endtask

    task automatic t_ctrl();
        wr_reg(csfu_pkg::CSFU_FLAGS_ADDR, 8'h00);
        op_only(csfu_pkg::CSFU_OP_SCF);
        chk8(8'h80, flags_out);
        op_only(csfu_pkg::CSFU_OP_CCF);
        chk8(8'h00, flags_out);
        op_only(csfu_pkg::CSFU_OP_CCF);
        chk8(8'h80, flags_out);
        op_only(csfu_pkg::CSFU_OP_RCF);
        chk8(8'h00, flags_out);
        op_only(csfu_pkg::CSFU_OP_SBO);
        chk8(8'h01, flags_out);
        op_only(csfu_pkg::CSFU_OP_SBZ);
        chk8(8'h00, flags_out);
        op_only(csfu_pkg::CSFU_OP_FENT);
        chk8(8'hC0, {flags_out[1], int_block, 6'h00});
        op_only(csfu_pkg::CSFU_OP_INT_RETURN);
        chk8(8'h20, {flags_out[1], int_block, fast_return, 5'h00});
        op_only(csfu_pkg::CSFU_OP_INT_RETURN);
        chk8(8'h00, {7'h00, fast_return});
        $display("test control done");
    endtask

    task automatic t_cond();
        logic [7:0] pat [2];
        pat[0] = 8'h08;
        pat[1] = 8'hB0;
        for (int p = 0; p < 2; p++)
        begin
            wr_reg(csfu_pkg::CSFU_FLAGS_ADDR, pat[p]);
            for (int c = 0; c < 16; c++)
            begin
                @(posedge sys_clk);
                cond_code <= c[3:0];
                @(posedge sys_clk);
                #1;
                chk8({7'h00, cond_ref(pat[p], c[3:0])}, {7'h00, cond_true});
            end
        end
        $display("test condition done");
    endtask

    task automatic br_chk(input logic [15:0] pc, input logic [7:0] off, input logic [7:0] pa,
                          input logic w, input logic [15:0] exp_t, input logic exp_ok);
        @(posedge sys_clk);
        next_pc <= pc;
        br_offset <= off;
        pair_addr <= pa;
        pair_is_wreg <= w;
        @(posedge sys_clk);
        #1;
        chk16(exp_t, br_target);
        chk8({7'h00, exp_ok}, {7'h00, pair_ok});
    endtask

    task automatic t_branch();
        br_chk(16'h1000, 8'h80, 8'hFE, 1'h0, 16'h0F80, 1'h1);
        br_chk(16'h1000, 8'h7F, 8'hFF, 1'h0, 16'h107F, 1'h0);
        br_chk(16'h0000, 8'hFF, 8'h0E, 1'h1, 16'hFFFF, 1'h1);
        br_chk(16'hFFFF, 8'h01, 8'h10, 1'h1, 16'h0000, 1'h0);
        $display("test branch done");
    endtask

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    initial
    begin
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        rst = 1'h1;
        req = '0;
        bus = '0;
        cond_code = 4'h0;
        next_pc = 16'h0000;
        br_offset = 8'h00;
        pair_addr = 8'h00;
        pair_is_wreg = 1'h0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        #1;
        t_regs();
        t_arith();
        t_logic();
        t_rotate();
        t_ctrl();
        t_cond();
        t_branch();
        end_of_test();
    end
endmodule
